/* bench/ext_int_source.sv */
// Model of the external interrupt source that drives the request line
`timescale 1ns/100ps
module ext_int_source (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic ack,
    output logic ext_int_req
);
    // ==========================================
    // Request hold
    logic req_q;
    logic req_d;
    // Raise on fire, keep it up until ack; ack wins over fire in the same cycle
    always_comb begin
        req_d = req_q;
        if (fire) begin
            req_d = 1'b1;
        end
        if (ack) begin
            req_d = 1'b0;
        end
    end
    // Register the request, changes land just after the edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end
    assign ext_int_req = req_q;
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the exception vector and cause logic
`timescale 1ns/100ps
module tb_top;
    import exc_pkg::*;
    // ==========================================
    // Signals
    typedef struct packed {
        logic [20:0] in;
        logic take;
        logic [19:0] vec;
        logic [3:0] st;
    } tb_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [20:0] cause_w = '0; // Per-instruction causes and state bits
    logic fex_clear = 1'b0;
    logic interrupt_enable = 1'b0;
    logic dec_msb = 1'b0;
    logic inflight_empty = 1'b0;
    logic handler_started = 1'b0;
    logic fire = 1'b0;
    logic ack = 1'b0;
    logic ext_int_req;
    logic dispatch_stall_q;
    logic exc_take_q;
    logic misalign_fixup_q;
    logic [VEC_W-1:0] exc_vector_q;
    logic [RSN_W-1:0] saved_status_q;
    int mismatches = 0;
    int num_checks = 0;
    logic seen;
    logic fix_seen;
    tb_row_t rows [0:20];
    // Clock
    always #2.5 core_clk = ~core_clk;
    // ==========================================
    // Design and partner
    exception_vector_cause_logic i_exception_vector_cause_logic (
        .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .fetch_access_fault(cause_w[20]), .data_fault(cause_w[19]), .ls_access(cause_w[18]),
        .mem_ctrl_access(cause_w[17]), .cache_ctrl_access(cause_w[16]), .align_fault(cause_w[15]),
        .align_hw_fix(cause_w[14]), .illegal_opcode(cause_w[13]), .unimpl_optional(cause_w[12]),
        .privileged_op(cause_w[11]), .spr_move(cause_w[10]), .spr_field_bit0(cause_w[9]),
        .spr_field_invalid(cause_w[8]), .trap_condition_met(cause_w[7]), .fp_exc_enabled(cause_w[6]),
        .move_to_float_status_control_register(cause_w[5]), .float_status_control_register_exc_set(cause_w[4]), .float_status_control_register_en_set(cause_w[3]),
        .fex_clear(fex_clear), .user_mode_flag(cause_w[2]), .fp_mode_bit0(cause_w[1]),
        .fp_mode_bit1(cause_w[0]), .ext_int_req(ext_int_req), .interrupt_enable(interrupt_enable),
        .dec_msb(dec_msb), .inflight_empty(inflight_empty), .handler_started(handler_started),
        .dispatch_stall_q(dispatch_stall_q), .exc_take_q(exc_take_q), .exc_vector_q(exc_vector_q),
        .saved_status_q(saved_status_q), .misalign_fixup_q(misalign_fixup_q)
    );
    ext_int_source i_ext_int_source (
        .core_clk(core_clk), .rst_n(rst_n), .fire(fire), .ack(ack), .ext_int_req(ext_int_req)
    );
    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Bounded watch for an entry pulse, noting any fix-up pulse too
    task automatic watch_take(input int n);
        seen = 1'b0;
        fix_seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            if (misalign_fixup_q === 1'b1) fix_seen = 1'b1;
            if (exc_take_q === 1'b1) seen = 1'b1;
            else @(negedge core_clk);
        end
    endtask
    // One completing instruction for one cycle
    task automatic issue(input logic [20:0] w);
        cause_w = w;
        instr_valid = 1'b1;
        @(negedge core_clk);
        cause_w = '0;
        instr_valid = 1'b0;
    endtask
    task automatic expect_entry(input logic [19:0] vec, input logic [3:0] st);
        watch_take(6);
        check(seen, 1'b1);
        if (seen !== 1'b1) test_done();
        check(exc_vector_q, vec);
        check(saved_status_q, st);
    endtask
    // Handler start ends the entry wait and clears the float summary
    task automatic finish_entry(input logic a);
        handler_started = 1'b1;
        fex_clear = 1'b1;
        ack = a;
        @(negedge core_clk);
        handler_started = 1'b0;
        fex_clear = 1'b0;
        ack = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic run_row(input tb_row_t r);
        issue(r.in);
        watch_take(5);
        check(seen, r.take);
        check(fix_seen, r.in[15] & r.in[14]);
        if (seen === 1'b1) check(exc_vector_q, r.vec);
        if (seen === 1'b1) check(saved_status_q, r.st);
        finish_entry(1'b0);
    endtask
    // ==========================================
    // Monitors
    // The unavailable float vector must never show
    always @(negedge core_clk) begin
        if (exc_take_q === 1'b1) check(exc_vector_q === VEC_FPU, 1'b0);
    end
    // Overall time limit
    initial begin
        #500000;
        check(1'b0, 1'b1);
        test_done();
    end
    // ==========================================
    // Main sequence
    initial begin
        rows = '{
            '{21'h100000, 1'b1, VEC_FETCH, 4'h0}, '{21'h0c0000, 1'b1, VEC_DATA, 4'h0},
            '{21'h0a0000, 1'b1, VEC_DATA, 4'h0}, '{21'h090000, 1'b1, VEC_DATA, 4'h0},
            '{21'h080000, 1'b0, 20'h00000, 4'h0}, '{21'h008000, 1'b1, VEC_ALIGN, 4'h0},
            '{21'h00c000, 1'b0, 20'h00000, 4'h0}, '{21'h002000, 1'b1, VEC_PROG, 4'h2},
            '{21'h001000, 1'b1, VEC_PROG, 4'h2}, '{21'h000804, 1'b1, VEC_PROG, 4'h4},
            '{21'h000800, 1'b0, 20'h00000, 4'h0}, '{21'h000704, 1'b1, VEC_PROG, 4'h4},
            '{21'h000700, 1'b0, 20'h00000, 4'h0}, '{21'h000080, 1'b1, VEC_PROG, 4'h8},
            '{21'h000042, 1'b1, VEC_PROG, 4'h1}, '{21'h000039, 1'b1, VEC_PROG, 4'h1},
            '{21'h000040, 1'b0, 20'h00000, 4'h0}, '{21'h000002, 1'b0, 20'h00000, 4'h0},
            '{21'h1c8080, 1'b1, VEC_FETCH, 4'h0}, '{21'h0ca000, 1'b1, VEC_DATA, 4'h0},
            '{21'h008080, 1'b1, VEC_ALIGN, 4'h0}
        };
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check({dispatch_stall_q, exc_take_q, misalign_fixup_q, saved_status_q, exc_vector_q}, '0);
        foreach (rows[i]) run_row(rows[i]);
        // External request refused while disabled, then drained and taken
        fire = 1'b1;
        @(negedge core_clk);
        fire = 1'b0;
        watch_take(6);
        check({seen, dispatch_stall_q}, 2'b00);
        interrupt_enable = 1'b1;
        repeat (2) @(negedge core_clk);
        check(dispatch_stall_q, 1'b1);
        watch_take(6);
        check(seen, 1'b0);
        inflight_empty = 1'b1;
        expect_entry(VEC_EXT, 4'h0);
        inflight_empty = 1'b0;
        finish_entry(1'b1);
        check({ext_int_req, dispatch_stall_q}, 2'b00);
        // Fault of an instruction still in flight wins over the request
        fire = 1'b1;
        @(negedge core_clk);
        fire = 1'b0;
        repeat (2) @(negedge core_clk);
        issue(21'h0c0000);
        expect_entry(VEC_DATA, 4'h0);
        finish_entry(1'b0);
        inflight_empty = 1'b1;
        expect_entry(VEC_EXT, 4'h0);
        inflight_empty = 1'b0;
        finish_entry(1'b1);
        // Decrementer edge held pending while disabled
        interrupt_enable = 1'b0;
        dec_msb = 1'b1;
        watch_take(8);
        check(seen, 1'b0);
        interrupt_enable = 1'b1;
        expect_entry(VEC_DEC, 4'h0);
        finish_entry(1'b0);
        watch_take(6);
        check(seen, 1'b0);
        dec_msb = 1'b0;
        watch_take(4);
        check(seen, 1'b0);
        // Reset in mid-drain clears the stall at once
        fire = 1'b1;
        @(negedge core_clk);
        fire = 1'b0;
        repeat (2) @(negedge core_clk);
        check(dispatch_stall_q, 1'b1);
        rst_n = 1'b0;
        @(negedge core_clk);
        check({dispatch_stall_q, exc_take_q, exc_vector_q}, '0);
        rst_n = 1'b1;
        // Second release: quiet outputs, then a first fault is still taken
        repeat (3) @(negedge core_clk);
        check({dispatch_stall_q, exc_take_q, ext_int_req}, 3'b000);
        issue(21'h100000);
        expect_entry(VEC_FETCH, 4'h0);
        finish_entry(1'b0);
        test_done();
    end
endmodule

/* logic/decrementer_pending.sv */
// Decrementer edge capture and pending hold
`timescale 1ns/100ps
module decrementer_pending
    import exc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_sync_n,
    exc_cause_if.dec_side c
);
    typedef struct packed {
        logic msb_prev;
        logic pending;
    } dec_state_t;
    dec_state_t cur_q, nxt_d;
    logic rise;

    // ==========================================
    // Rising top bit sets pending, taking clears it
    always_comb begin
        nxt_d = cur_q;
        nxt_d.msb_prev = c.dec_msb;
        rise = c.dec_msb & ~cur_q.msb_prev;
        if (c.dec_taken) begin
            nxt_d.pending = 1'b0;
        end
        if (rise) begin
            nxt_d.pending = 1'b1;
        end
    end

    assign c.dec_request = cur_q.pending & c.int_enable;

    // State register
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    chk_dec_edge_pend: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        rise |=> cur_q.pending) else $error("decrementer edge lost");
    chk_dec_hold_pend: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        cur_q.pending && !c.int_enable |=> cur_q.pending) else $error("pending decrementer dropped");
endmodule

/* logic/exception_vector_cause_logic.sv */
// Exception cause recognition, prioritising and vector selection
`timescale 1ns/100ps
module exception_vector_cause_logic
    import exc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic fetch_access_fault,
    input wire logic data_fault,
    input wire logic ls_access,
    input wire logic mem_ctrl_access,
    input wire logic cache_ctrl_access,
    input wire logic align_fault,
    input wire logic align_hw_fix,
    input wire logic illegal_opcode,
    input wire logic unimpl_optional,
    input wire logic privileged_op,
    input wire logic spr_move,
    input wire logic spr_field_bit0,
    input wire logic spr_field_invalid,
    input wire logic trap_condition_met,
    input wire logic fp_exc_enabled,
    input wire logic move_to_float_status_control_register,
    input wire logic float_status_control_register_exc_set,
    input wire logic float_status_control_register_en_set,
    input wire logic fex_clear,
    input wire logic user_mode_flag,
    input wire logic fp_mode_bit0,
    input wire logic fp_mode_bit1,
    input wire logic ext_int_req,
    input wire logic interrupt_enable,
    input wire logic dec_msb,
    input wire logic inflight_empty,
    input wire logic handler_started,
    output logic dispatch_stall_q,
    output logic exc_take_q,
    output logic [VEC_W-1:0] exc_vector_q,
    output logic [RSN_W-1:0] saved_status_q,
    output logic misalign_fixup_q
);

    // ==========================================
    // Reset release

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;

    // Two stage release of the async reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe_q[1];

    // ==========================================
    // Helper blocks

    exc_cause_if c ();

    // Program cause inputs
    assign c.exec_valid = instr_valid;
    assign c.illegal_op = illegal_opcode;
    assign c.unimpl_opt = unimpl_optional;
    assign c.priv_op = privileged_op;
    assign c.spr_move = spr_move;
    assign c.spr_bit0 = spr_field_bit0;
    assign c.spr_bad = spr_field_invalid;
    assign c.trap_met = trap_condition_met;
    assign c.fp_exc_enabled = fp_exc_enabled;
    assign c.mtfs_exc = move_to_float_status_control_register & float_status_control_register_exc_set;
    assign c.mtfs_en = move_to_float_status_control_register & float_status_control_register_en_set;
    assign c.fex_clear = fex_clear;
    assign c.user_mode_flag = user_mode_flag;
    assign c.fp_mode_bit0 = fp_mode_bit0;
    assign c.fp_mode_bit1 = fp_mode_bit1;

    // Decrementer inputs
    assign c.dec_msb = dec_msb;
    assign c.int_enable = interrupt_enable;

    program_cause_decode u_prog (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .c(c.prog_side)
    );

    decrementer_pending u_dec (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .c(c.dec_side)
    );

    // ==========================================
    // Cause recognition

    logic fetch_hit;
    logic data_hit;
    logic align_hit;
    logic prog_hit;
    logic sync_hit;
    logic fix_hit;
    logic ext_ready;

    // Faults carried by the completing instruction
    assign fetch_hit = instr_valid & fetch_access_fault;
    assign data_hit = instr_valid & data_fault
        & (ls_access | mem_ctrl_access | cache_ctrl_access);
    assign align_hit = instr_valid & align_fault & ~align_hw_fix;
    assign fix_hit = instr_valid & align_fault & align_hw_fix;
    assign prog_hit = c.prog_hit;
    assign sync_hit = fetch_hit | data_hit | align_hit | prog_hit;

    // External line qualified by the enable
    assign ext_ready = ext_int_req & interrupt_enable;

    // ==========================================
    // Vector priority

    // Fetch, data, alignment, program in that order
    function automatic logic [VEC_W-1:0] sync_vector(
        input logic f,
        input logic d,
        input logic a
    );
        logic [VEC_W-1:0] v;
        v = VEC_PROG;
        if (a) begin
            v = VEC_ALIGN;
        end
        if (d) begin
            v = VEC_DATA;
        end
        if (f) begin
            v = VEC_FETCH;
        end
        return v;
    endfunction

    // ==========================================
    // Sequencer state

    typedef struct packed {
        seq_state_t st;
        logic stall;
        logic take;
        logic [VEC_W-1:0] vec;
        logic [RSN_W-1:0] rsn;
        logic fixup;
    } seq_t;

    seq_t cur_q, nxt_d;
    logic dec_take;
    logic in_drain;

    assign in_drain = (cur_q.st == ST_DRAIN);
    assign c.dec_taken = dec_take;

    // Next state and entry selection
    always_comb begin
        nxt_d = cur_q;
        nxt_d.take = 1'b0;
        nxt_d.fixup = fix_hit;
        dec_take = 1'b0;
        case (cur_q.st)
            ST_RUN: begin
                if (sync_hit) begin
                    nxt_d.take = 1'b1;
                    nxt_d.vec = sync_vector(fetch_hit, data_hit, align_hit);
                    nxt_d.rsn = (fetch_hit | data_hit | align_hit) ? RSN_RESET : c.prog_reason;
                    nxt_d.stall = 1'b1;
                    nxt_d.st = ST_WAIT;
                end else if (ext_ready) begin
                    nxt_d.stall = 1'b1;
                    nxt_d.st = ST_DRAIN;
                end else if (c.dec_request) begin
                    nxt_d.take = 1'b1;
                    nxt_d.vec = VEC_DEC;
                    nxt_d.rsn = RSN_RESET;
                    nxt_d.stall = 1'b1;
                    nxt_d.st = ST_WAIT;
                    dec_take = 1'b1;
                end
            end
            ST_DRAIN: begin
                nxt_d.stall = 1'b1;
                if (sync_hit) begin
                    nxt_d.take = 1'b1;
                    nxt_d.vec = sync_vector(fetch_hit, data_hit, align_hit);
                    nxt_d.rsn = (fetch_hit | data_hit | align_hit) ? RSN_RESET : c.prog_reason;
                    nxt_d.st = ST_WAIT;
                end else if (inflight_empty) begin
                    nxt_d.take = 1'b1;
                    nxt_d.vec = VEC_EXT;
                    nxt_d.rsn = RSN_RESET;
                    nxt_d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                nxt_d.stall = 1'b1;
                if (handler_started) begin
                    nxt_d.stall = 1'b0;
                    nxt_d.st = ST_RUN;
                end
            end
            default: begin
                nxt_d.stall = 1'b0;
                nxt_d.st = ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur_q <= '{st: ST_RUN, stall: 1'b0, take: 1'b0,
                vec: VEC_RESET, rsn: RSN_RESET, fixup: 1'b0};
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ==========================================
    // Outputs

    // All outputs come from the state register
    assign dispatch_stall_q = cur_q.stall;
    assign exc_take_q = cur_q.take;
    assign exc_vector_q = cur_q.vec;
    assign saved_status_q = cur_q.rsn;
    assign misalign_fixup_q = cur_q.fixup;

    // ==========================================
    // Checks

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_ext_take;
        exc_take_q && exc_vector_q == VEC_EXT;
    endsequence

    sequence s_drain_entry;
        cur_q.st == ST_RUN && ext_ready && !sync_hit;
    endsequence

    chk_ext_after_drain: assert property (
        s_ext_take |-> $past(in_drain) && $past(inflight_empty))
        else $error("external taken without drain");

    chk_stall_on_req: assert property (
        s_drain_entry |=> dispatch_stall_q && in_drain ##1 dispatch_stall_q)
        else $error("dispatch not stopped on request");

    chk_sync_before_ext: assert property (
        in_drain && sync_hit |=> exc_take_q && exc_vector_q != VEC_EXT)
        else $error("pending external beat an instruction fault");

    chk_data_vector: assert property (
        cur_q.st != ST_WAIT && data_hit && !fetch_hit |=> exc_take_q && exc_vector_q == VEC_DATA)
        else $error("data fault not vectored");

    chk_fetch_vector: assert property (
        cur_q.st != ST_WAIT && fetch_hit |=> exc_take_q && exc_vector_q == VEC_FETCH)
        else $error("fetch fault not vectored");

    chk_align_fixed: assert property (
        fix_hit && !data_hit && !fetch_hit && !prog_hit |=> !exc_take_q || exc_vector_q != VEC_ALIGN)
        else $error("fixable misalignment reached handler");

    chk_prog_reason: assert property (
        exc_take_q && exc_vector_q == VEC_PROG |-> saved_status_q != RSN_RESET)
        else $error("program entry without cause bit");

    chk_no_fpu_vec: assert property (
        exc_take_q |-> exc_vector_q != VEC_FPU)
        else $error("unimplemented vector produced");

    chk_dec_vector: assert property (
        cur_q.st == ST_RUN && !sync_hit && !ext_ready && c.dec_request
        |=> exc_take_q && exc_vector_q == VEC_DEC)
        else $error("decrementer not taken");

    chk_wait_holds: assert property (
        exc_take_q |=> !exc_take_q)
        else $error("two entries back to back");

    chk_stall_release: assert property (
        cur_q.st == ST_WAIT && handler_started |=> !dispatch_stall_q)
        else $error("stall kept after handler start");

    chk_dec_needs_enable: assert property (
        exc_take_q && exc_vector_q == VEC_DEC |-> $past(interrupt_enable))
        else $error("decrementer taken while disabled");

    chk_data_kind_only: assert property (
        instr_valid && data_fault && !ls_access && !mem_ctrl_access && !cache_ctrl_access
        |=> !(exc_take_q && exc_vector_q == VEC_DATA))
        else $error("data entry without access kind");

endmodule

/* logic/program_cause_decode.sv */
// Program exception cause decode with float summary flag
`timescale 1ns/100ps
module program_cause_decode
    import exc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_sync_n,
    exc_cause_if.prog_side c
);
    typedef struct packed {
        logic fp_enabled_summary;
    } prog_state_t;
    prog_state_t cur_q, nxt_d;
    logic fex_set;
    logic [RSN_W-1:0] rsn;

    // ==========================================
    // Summary flag and cause bits
    always_comb begin
        nxt_d = cur_q;
        fex_set = c.exec_valid & (c.fp_exc_enabled | (c.mtfs_exc & c.mtfs_en));
        if (c.fex_clear) begin
            nxt_d.fp_enabled_summary = 1'b0;
        end
        if (fex_set) begin
            nxt_d.fp_enabled_summary = 1'b1; // Set beats clear
        end
        rsn = RSN_RESET;
        rsn[RSN_FP] = c.exec_valid & (cur_q.fp_enabled_summary | fex_set) & (c.fp_mode_bit0 | c.fp_mode_bit1);
        rsn[RSN_ILL] = c.exec_valid & (c.illegal_op | c.unimpl_opt);
        rsn[RSN_PRIV] = c.exec_valid & c.user_mode_flag
            & (c.priv_op | (c.spr_move & c.spr_bad & c.spr_bit0));
        rsn[RSN_TRAP] = c.exec_valid & c.trap_met;
    end

    assign c.prog_reason = rsn;
    assign c.prog_hit = |rsn;

    // State register
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    chk_fex_sets_sticky: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        fex_set |=> cur_q.fp_enabled_summary) else $error("summary flag not set");
    chk_priv_user_only: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        c.exec_valid && c.priv_op && c.user_mode_flag |-> c.prog_reason[RSN_PRIV])
        else $error("privileged cause missed in user mode");
endmodule

/* pkg/exc_cause_if.sv */
// Bundle between the sequencer and its cause helpers
`timescale 1ns/100ps
interface exc_cause_if
    import exc_pkg::*;
    ();
    logic exec_valid;
    logic illegal_op;
    logic unimpl_opt;
    logic priv_op;
    logic spr_move;
    logic spr_bit0;
    logic spr_bad;
    logic trap_met;
    logic fp_exc_enabled;
    logic mtfs_exc;
    logic mtfs_en;
    logic fex_clear;
    logic user_mode_flag;
    logic fp_mode_bit0;
    logic fp_mode_bit1;
    logic prog_hit;
    logic [RSN_W-1:0] prog_reason;
    logic dec_msb;
    logic int_enable;
    logic dec_taken;
    logic dec_request;
    modport prog_side (input exec_valid, illegal_op, unimpl_opt, priv_op, spr_move,
        spr_bit0, spr_bad, trap_met, fp_exc_enabled, mtfs_exc, mtfs_en, fex_clear,
        user_mode_flag, fp_mode_bit0, fp_mode_bit1, output prog_hit, prog_reason);
    modport dec_side (input dec_msb, int_enable, dec_taken, output dec_request);
endinterface

/* pkg/exc_pkg.sv */
// Constants and types shared by the exception vector and cause logic
package exc_pkg;
    // ==========================================
    // Vector offsets
    localparam int VEC_W = 20;
    localparam logic [19:0] VEC_RESET = 20'h00000;
    localparam logic [19:0] VEC_DATA = 20'h00300;
    localparam logic [19:0] VEC_FETCH = 20'h00400;
    localparam logic [19:0] VEC_EXT = 20'h00500;
    localparam logic [19:0] VEC_ALIGN = 20'h00600;
    localparam logic [19:0] VEC_PROG = 20'h00700;
    localparam logic [19:0] VEC_FPU = 20'h00800;
    localparam logic [19:0] VEC_DEC = 20'h00900;
    // ==========================================
    // Saved status cause bit positions
    localparam int RSN_W = 4;
    localparam int RSN_FP = 0;
    localparam int RSN_ILL = 1;
    localparam int RSN_PRIV = 2;
    localparam int RSN_TRAP = 3;
    localparam logic [3:0] RSN_RESET = 4'h0;
    // ==========================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DRAIN = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_t;
endpackage
